// ===== core/abu_breakpoint.sv
`default_nettype none
module abu_breakpoint
    import abu_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire abu_cpu_in_s cpu_in,
    output abu_cpu_out_s cpu_out,
    output logic irq,
    input wire logic [ABU_AXI_ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ABU_AXI_ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // Bus slave state
    logic aw_held_reg, aw_held_next;
    logic [ABU_AXI_ADDR_W-1:0] aw_addr_reg, aw_addr_next;
    logic w_held_reg, w_held_next;
    logic [7:0] w_byte_reg, w_byte_next;
    logic w_lane_reg, w_lane_next;
    logic bvalid_reg, bvalid_next;
    logic [1:0] bresp_reg, bresp_next;
    logic rvalid_reg, rvalid_next;
    logic [1:0] rresp_reg, rresp_next;
    logic [31:0] rdata_reg, rdata_next;

    // Break state
    abu_state_e state_reg, state_next;
    logic [7:0] bp_addr_hi_reg, bp_addr_hi_next;
    logic [7:0] bp_addr_lo_reg, bp_addr_lo_next;
    logic bp_match_enable_reg, bp_match_enable_next;
    logic bp_active_flag_reg, bp_active_flag_next;
    logic flag_clear_permit_reg, flag_clear_permit_next;
    logic stopwait_exit_by_bp_flag_reg, stopwait_exit_by_bp_flag_next;
    logic [ABU_IRQ_W-1:0] irq_status_reg, irq_status_next;
    logic [ABU_IRQ_W-1:0] irq_mask_reg, irq_mask_next;
    logic [15:0] vector_reg, vector_next;

    // Combinational helpers
    logic wr_fire;
    logic [15:0] wr_idx;
    logic wr_hit;
    logic [15:0] rd_idx;
    logic addr_match;
    logic sw_trigger;
    logic trigger;
    logic want_break;
    logic take_break;
    logic [ABU_IRQ_W-1:0] irq_events;
    logic [7:0] status_ctrl_view;

    assign s_axi_awready = !aw_held_reg && !bvalid_reg;
    assign s_axi_wready = !w_held_reg && !bvalid_reg;
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rresp = rresp_reg;
    assign s_axi_rdata = rdata_reg;

    // A write is performed once both address and data are held
    assign wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;
    assign wr_idx = aw_addr_reg[ABU_AXI_ADDR_W-1:2];
    assign rd_idx = s_axi_araddr[ABU_AXI_ADDR_W-1:2];

    // Comparator idle in stop mode, PC addresses only
    assign addr_match = bp_match_enable_reg
        && cpu_in.addr_from_pc
        && !cpu_in.stop_mode
        && (cpu_in.addr == {bp_addr_hi_reg, bp_addr_lo_reg});

    // Only the low byte lane carries the registers
    assign sw_trigger = wr_fire && w_lane_reg && (wr_idx == ABU_IDX_BP_STATUS_CTRL)
        && w_byte_reg[ABU_BIT_ACTIVE_FLAG];
    assign trigger = addr_match || sw_trigger;
    assign want_break = (state_reg == ABU_PENDING) || (state_reg == ABU_IDLE && trigger);
    // Boundary taken same cycle when the match lands on the last cycle
    assign take_break = want_break && cpu_in.instr_last_cycle;

    assign status_ctrl_view = {bp_match_enable_reg, bp_active_flag_reg, 6'h00};

    always_comb begin
        aw_held_next = aw_held_reg;
        aw_addr_next = aw_addr_reg;
        w_held_next = w_held_reg;
        w_byte_next = w_byte_reg;
        w_lane_next = w_lane_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        rvalid_next = rvalid_reg;
        rresp_next = rresp_reg;
        rdata_next = rdata_reg;
        wr_hit = 1'b0;

        if (s_axi_awvalid && s_axi_awready) begin
            aw_held_next = 1'b1;
            aw_addr_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_held_next = 1'b1;
            w_byte_next = s_axi_wdata[7:0];
            w_lane_next = s_axi_wstrb[0];
        end
        if (wr_fire) begin
            if (wr_idx == ABU_IDX_BP_ADDR_HI) begin
                wr_hit = 1'b1;
            end else if (wr_idx == ABU_IDX_BP_ADDR_LO) begin
                wr_hit = 1'b1;
            end else if (wr_idx == ABU_IDX_BP_STATUS_CTRL) begin
                wr_hit = 1'b1;
            end else if (wr_idx == ABU_IDX_BP_FLAG_CONTROL) begin
                wr_hit = 1'b1;
            end else if (wr_idx == ABU_IDX_STOPWAIT_STATUS) begin
                wr_hit = 1'b1;
            end else if (wr_idx == ABU_IDX_IRQ_STATUS) begin
                wr_hit = 1'b1;
            end else if (wr_idx == ABU_IDX_IRQ_MASK) begin
                wr_hit = 1'b1;
            end
            aw_held_next = 1'b0;
            w_held_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = wr_hit ? ABU_RESP_OKAY : ABU_RESP_SLVERR;
        end else if (bvalid_reg && s_axi_bready) begin
            bvalid_next = 1'b0;
        end

        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_next = 1'b1;
            rresp_next = ABU_RESP_OKAY;
            rdata_next = 32'h0000_0000;
            if (rd_idx == ABU_IDX_BP_ADDR_HI) begin
                rdata_next[7:0] = bp_addr_hi_reg;
            end else if (rd_idx == ABU_IDX_BP_ADDR_LO) begin
                rdata_next[7:0] = bp_addr_lo_reg;
            end else if (rd_idx == ABU_IDX_BP_STATUS_CTRL) begin
                rdata_next[7:0] = status_ctrl_view;
            end else if (rd_idx == ABU_IDX_BP_FLAG_CONTROL) begin
                rdata_next[ABU_BIT_FLAG_CLEAR_PERMIT] = flag_clear_permit_reg;
            end else if (rd_idx == ABU_IDX_STOPWAIT_STATUS) begin
                rdata_next[ABU_BIT_STOPWAIT_EXIT] = stopwait_exit_by_bp_flag_reg;
            end else if (rd_idx == ABU_IDX_IRQ_STATUS) begin
                rdata_next[ABU_IRQ_W-1:0] = irq_status_reg;
            end else if (rd_idx == ABU_IDX_IRQ_MASK) begin
                rdata_next[ABU_IRQ_W-1:0] = irq_mask_reg;
            end else begin
                rresp_next = ABU_RESP_SLVERR;
            end
        end else if (rvalid_reg && s_axi_rready) begin
            rvalid_next = 1'b0;
        end
    end

    always_comb begin
        state_next = state_reg;
        bp_addr_hi_next = bp_addr_hi_reg;
        bp_addr_lo_next = bp_addr_lo_reg;
        bp_match_enable_next = bp_match_enable_reg;
        bp_active_flag_next = bp_active_flag_reg;
        flag_clear_permit_next = flag_clear_permit_reg;
        stopwait_exit_by_bp_flag_next = stopwait_exit_by_bp_flag_reg;
        irq_status_next = irq_status_reg;
        irq_mask_next = irq_mask_reg;
        vector_next = cpu_in.monitor_mode ? ABU_VEC_MONITOR : ABU_VEC_USER;
        irq_events = '0;

        // Software writes first so hardware sets below win
        if (wr_fire && w_lane_reg) begin
            if (wr_idx == ABU_IDX_BP_ADDR_HI) begin
                bp_addr_hi_next = w_byte_reg;
            end else if (wr_idx == ABU_IDX_BP_ADDR_LO) begin
                bp_addr_lo_next = w_byte_reg;
            end else if (wr_idx == ABU_IDX_BP_STATUS_CTRL) begin
                bp_match_enable_next = w_byte_reg[ABU_BIT_MATCH_ENABLE];
                bp_active_flag_next = w_byte_reg[ABU_BIT_ACTIVE_FLAG];
            end else if (wr_idx == ABU_IDX_BP_FLAG_CONTROL) begin
                flag_clear_permit_next = w_byte_reg[ABU_BIT_FLAG_CLEAR_PERMIT];
            end else if (wr_idx == ABU_IDX_STOPWAIT_STATUS) begin
                if (w_byte_reg[ABU_BIT_STOPWAIT_EXIT]) begin
                    stopwait_exit_by_bp_flag_next = 1'b0;
                end
            end else if (wr_idx == ABU_IDX_IRQ_STATUS) begin
                irq_status_next = irq_status_reg & ~w_byte_reg[ABU_IRQ_W-1:0];
            end else if (wr_idx == ABU_IDX_IRQ_MASK) begin
                irq_mask_next = w_byte_reg[ABU_IRQ_W-1:0];
            end
        end

        if (addr_match) begin
            bp_active_flag_next = 1'b1;
            irq_events[ABU_IRQ_MATCH] = 1'b1;
        end

        case (state_reg)
            ABU_IDLE: begin
                if (take_break) begin
                    state_next = ABU_IN_BREAK;
                end else if (trigger) begin
                    state_next = ABU_PENDING;
                end
            end
            ABU_PENDING: begin
                if (take_break) begin
                    state_next = ABU_IN_BREAK;
                end
            end
            ABU_IN_BREAK: begin
                // New triggers inside the handler are not queued
                if (cpu_in.ret_done) begin
                    state_next = ABU_IDLE;
                    irq_events[ABU_IRQ_ENDED] = 1'b1;
                end
            end
            default: begin
                state_next = ABU_IDLE;
            end
        endcase

        if (take_break) begin
            irq_events[ABU_IRQ_TAKEN] = 1'b1;
            if (cpu_in.wait_mode || cpu_in.stop_mode) begin
                stopwait_exit_by_bp_flag_next = 1'b1;
            end
        end

        irq_status_next = irq_status_next | irq_events;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            aw_held_reg <= 1'b0;
            aw_addr_reg <= '0;
            w_held_reg <= 1'b0;
            w_byte_reg <= ABU_RST_BYTE;
            w_lane_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= ABU_RESP_OKAY;
            rvalid_reg <= 1'b0;
            rresp_reg <= ABU_RESP_OKAY;
            rdata_reg <= 32'h0000_0000;
            state_reg <= ABU_IDLE;
            bp_addr_hi_reg <= ABU_RST_BYTE;
            bp_addr_lo_reg <= ABU_RST_BYTE;
            bp_match_enable_reg <= 1'b0;
            bp_active_flag_reg <= 1'b0;
            flag_clear_permit_reg <= 1'b0;
            stopwait_exit_by_bp_flag_reg <= 1'b0;
            irq_status_reg <= ABU_RST_IRQ;
            irq_mask_reg <= ABU_RST_IRQ;
            vector_reg <= ABU_VEC_USER;
        end else begin
            aw_held_reg <= aw_held_next;
            aw_addr_reg <= aw_addr_next;
            w_held_reg <= w_held_next;
            w_byte_reg <= w_byte_next;
            w_lane_reg <= w_lane_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            rvalid_reg <= rvalid_next;
            rresp_reg <= rresp_next;
            rdata_reg <= rdata_next;
            state_reg <= state_next;
            bp_addr_hi_reg <= bp_addr_hi_next;
            bp_addr_lo_reg <= bp_addr_lo_next;
            bp_match_enable_reg <= bp_match_enable_next;
            bp_active_flag_reg <= bp_active_flag_next;
            flag_clear_permit_reg <= flag_clear_permit_next;
            stopwait_exit_by_bp_flag_reg <= stopwait_exit_by_bp_flag_next;
            irq_status_reg <= irq_status_next;
            irq_mask_reg <= irq_mask_next;
            vector_reg <= vector_next;
        end
    end

    always_comb begin
        cpu_out.force_sw_irq = take_break;
        cpu_out.break_vector = vector_reg;
        cpu_out.break_req = want_break;
        cpu_out.timer_hold = (state_reg == ABU_IN_BREAK);
        cpu_out.watchdog_disable = (state_reg == ABU_IN_BREAK) && cpu_in.reset_pin_high_v;
        // Outside a break peripherals clear flags freely
        cpu_out.periph_flag_clear_ok = (state_reg != ABU_IN_BREAK) || flag_clear_permit_reg;
        cpu_out.lowpower_exit = want_break && (cpu_in.stop_mode || cpu_in.wait_mode);
    end

    assign irq = |(irq_status_reg & irq_mask_reg);
endmodule // abu_breakpoint
`default_nettype wire

// ===== core/abu_pkg.sv
`default_nettype none
package abu_pkg;
    // Register indices; byte address is four times the index
    localparam logic [15:0] ABU_IDX_BP_ADDR_HI = 16'hFE0C;
    localparam logic [15:0] ABU_IDX_BP_ADDR_LO = 16'hFE0D;
    localparam logic [15:0] ABU_IDX_BP_STATUS_CTRL = 16'hFE0E;
    localparam logic [15:0] ABU_IDX_BP_FLAG_CONTROL = 16'hFE0F;
    localparam logic [15:0] ABU_IDX_STOPWAIT_STATUS = 16'hFE10;
    localparam logic [15:0] ABU_IDX_IRQ_STATUS = 16'hFE11;
    localparam logic [15:0] ABU_IDX_IRQ_MASK = 16'hFE12;
    localparam int ABU_AXI_ADDR_W = 18;

    // Field positions
    localparam int ABU_BIT_MATCH_ENABLE = 7;
    localparam int ABU_BIT_ACTIVE_FLAG = 6;
    localparam int ABU_BIT_FLAG_CLEAR_PERMIT = 7;
    localparam int ABU_BIT_STOPWAIT_EXIT = 1;
    localparam int ABU_IRQ_MATCH = 0;
    localparam int ABU_IRQ_TAKEN = 1;
    localparam int ABU_IRQ_ENDED = 2;
    localparam int ABU_IRQ_W = 3;

    // Reset values
    localparam logic [7:0] ABU_RST_BYTE = 8'h00;
    localparam logic [ABU_IRQ_W-1:0] ABU_RST_IRQ = 3'h0;

    // Break vectors
    localparam logic [15:0] ABU_VEC_USER = 16'hFFFC;
    localparam logic [15:0] ABU_VEC_MONITOR = 16'hFEFC;

    localparam logic [1:0] ABU_RESP_OKAY = 2'h0;
    localparam logic [1:0] ABU_RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        ABU_IDLE = 2'b00,
        ABU_PENDING = 2'b01,
        ABU_IN_BREAK = 2'b10
    } abu_state_e;

    typedef struct packed {
        logic [15:0] addr;
        logic addr_from_pc;
        logic instr_last_cycle;
        logic ret_done;
        logic monitor_mode;
        logic reset_pin_high_v;
        logic wait_mode;
        logic stop_mode;
    } abu_cpu_in_s;

    typedef struct packed {
        logic force_sw_irq;
        logic [15:0] break_vector;
        logic break_req;
        logic timer_hold;
        logic watchdog_disable;
        logic periph_flag_clear_ok;
        logic lowpower_exit;
    } abu_cpu_out_s;
endpackage
`default_nettype wire

// ===== verif/abu_breakpoint_properties.sv
`default_nettype none
module abu_breakpoint_properties
    import abu_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire abu_cpu_in_s cpu_in,
    input wire abu_cpu_out_s cpu_out,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_bvalid
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    property p_vec;
        !$past(rst) |-> cpu_out.break_vector ==
            ($past(cpu_in.monitor_mode) ? ABU_VEC_MONITOR : ABU_VEC_USER);
    endproperty
    a_vec: assert property (p_vec)
        else $error("break vector does not follow mode");
    property p_force;
        cpu_out.force_sw_irq == (cpu_out.break_req && cpu_in.instr_last_cycle);
    endproperty
    a_force: assert property (p_force)
        else $error("forced interrupt not at instruction end");
    property p_enter;
        cpu_out.force_sw_irq |=> cpu_out.timer_hold;
    endproperty
    a_enter: assert property (p_enter)
        else $error("timer not held after break taken");
    property p_ret;
        cpu_out.timer_hold && cpu_in.ret_done |=> !cpu_out.timer_hold;
    endproperty
    a_ret: assert property (p_ret)
        else $error("break not ended by return");
    property p_hold;
        cpu_out.break_req && !cpu_out.force_sw_irq |=> cpu_out.break_req;
    endproperty
    a_hold: assert property (p_hold)
        else $error("break request dropped before taken");
    // Software trigger lands one cycle after the later of the address and data beats
    property p_cause;
        $rose(cpu_out.break_req) |-> (cpu_in.addr_from_pc && !cpu_in.stop_mode)
            || s_axi_bvalid || $past(s_axi_wvalid);
    endproperty
    a_cause: assert property (p_cause)
        else $error("break request without a cause");
    property p_wdog;
        cpu_out.watchdog_disable == (cpu_out.timer_hold && cpu_in.reset_pin_high_v);
    endproperty
    a_wdog: assert property (p_wdog)
        else $error("watchdog disable wrong");
    property p_flag;
        !cpu_out.timer_hold |-> cpu_out.periph_flag_clear_ok;
    endproperty
    a_flag: assert property (p_flag)
        else $error("flag clearing blocked outside break");
    property p_lp;
        cpu_out.lowpower_exit == (cpu_out.break_req && (cpu_in.wait_mode || cpu_in.stop_mode));
    endproperty
    a_lp: assert property (p_lp)
        else $error("low power exit wrong");
endmodule // abu_breakpoint_properties
bind abu_breakpoint abu_breakpoint_properties u_props (
    .clk, .rst, .cpu_in, .cpu_out, .s_axi_wvalid, .s_axi_bvalid
);
`default_nettype wire

// ===== verif/abu_cpu_model.sv
`default_nettype none
module abu_cpu_model
    import abu_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire abu_cpu_in_s ctl,
    input wire logic ret_go,
    input wire abu_cpu_out_s cpu_out,
    output var abu_cpu_in_s cpu_in,
    output var int sw_irq_count
);
    logic [1:0] phase;
    // Four-cycle instructions, so a request must wait for the last one
    always_ff @(posedge clk) begin
        if (rst) begin
            phase <= 2'h0;
            cpu_in <= '0;
            sw_irq_count <= 0;
        end else begin
            phase <= phase + 2'h1;
            cpu_in <= ctl;
            cpu_in.instr_last_cycle <= (phase == 2'h2);
            cpu_in.ret_done <= ret_go && cpu_out.timer_hold && !cpu_in.ret_done;
            if (cpu_out.force_sw_irq) begin
                sw_irq_count <= sw_irq_count + 1;
            end
        end
    end
endmodule // abu_cpu_model
`default_nettype wire

// ===== verif/abu_breakpoint_tb.sv
`default_nettype none
module abu_breakpoint_tb
    import abu_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst = 1'b1, ret_go = 1'b0, aw_v = 1'b0, w_v = 1'b0, ar_v = 1'b0;
    logic seen_sw_irq = 1'b0, seen_lp = 1'b0;
    logic aw_r, w_r, b_v, ar_r, r_v, irq;
    logic [1:0] b_resp, r_resp;
    logic [31:0] w_d = 32'h0000_0000, r_d;
    logic [ABU_AXI_ADDR_W-1:0] aw_a = '0, ar_a = '0;
    abu_cpu_in_s ctl = '0, cpu_in;
    abu_cpu_out_s cpu_out;
    int failures = 0, tests_run = 0, sw_irq_count;
    abu_breakpoint u_dut (.clk, .rst, .cpu_in, .cpu_out, .irq, .s_axi_awaddr(aw_a),
        .s_axi_awprot(3'h0), .s_axi_awvalid(aw_v), .s_axi_awready(aw_r), .s_axi_wdata(w_d),
        .s_axi_wstrb(4'h1), .s_axi_wvalid(w_v), .s_axi_wready(w_r), .s_axi_bresp(b_resp),
        .s_axi_bvalid(b_v), .s_axi_bready(1'b1), .s_axi_araddr(ar_a), .s_axi_arprot(3'h0),
        .s_axi_arvalid(ar_v), .s_axi_arready(ar_r), .s_axi_rdata(r_d), .s_axi_rresp(r_resp),
        .s_axi_rvalid(r_v), .s_axi_rready(1'b1));
    abu_cpu_model u_cpu (.clk, .rst, .ctl, .ret_go, .cpu_out, .cpu_in, .sw_irq_count);
    initial begin
        forever #2.5 clk = ~clk;
    end
    // One-cycle pulse may fire before the triggering write returns
    always @(negedge clk) begin
        if (cpu_out.force_sw_irq === 1'b1) begin
            seen_sw_irq = 1'b1;
            seen_lp = cpu_out.lowpower_exit;
        end
    end
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [15:0] idx, input logic [7:0] d, input logic [1:0] er);
        logic a;
        logic w;
        @(posedge clk);
        aw_a <= {idx, 2'b00};
        w_d <= {24'h00_0000, d};
        aw_v <= 1'b1;
        w_v <= 1'b1;
        a = 1'b1;
        w = 1'b1;
        // Channels may be taken on different edges
        while (a || w) begin
            @(posedge clk);
            if (aw_r === 1'b1) aw_v <= 1'b0;
            if (w_r === 1'b1) w_v <= 1'b0;
            a = a && aw_r !== 1'b1;
            w = w && w_r !== 1'b1;
        end
        do @(posedge clk); while (b_v !== 1'b1);
        chk("bresp", b_resp, er);
    endtask
    task automatic rchk(input logic [15:0] idx, input logic [7:0] exp, input logic [1:0] er);
        @(posedge clk);
        ar_a <= {idx, 2'b00};
        ar_v <= 1'b1;
        do @(posedge clk); while (ar_r !== 1'b1);
        ar_v <= 1'b0;
        do @(posedge clk); while (r_v !== 1'b1);
        chk("rdata", r_d[7:0], exp);
        chk("rresp", r_resp, er);
    endtask
    task automatic take_break(input logic [15:0] vec, input logic lp);
        int n;
        n = 0;
        while (seen_sw_irq !== 1'b1 && n < 40) begin
            @(negedge clk);
            n++;
        end
        chk("force_sw_irq", seen_sw_irq, 1'b1);
        chk("lowpower_exit", seen_lp, lp);
        seen_sw_irq = 1'b0;
        @(negedge clk);
        chk("timer_hold", cpu_out.timer_hold, 1'b1);
        chk("break_vector", cpu_out.break_vector, vec);
    endtask
    task automatic end_break;
        int n;
        @(posedge clk);
        ret_go <= 1'b1;
        n = 0;
        do @(negedge clk); while (cpu_out.timer_hold !== 1'b0 && ++n < 40);
        chk("timer_hold", cpu_out.timer_hold, 1'b0);
        @(posedge clk);
        ret_go <= 1'b0;
    endtask
    task automatic t_reset;
        rchk(ABU_IDX_BP_ADDR_HI, 8'h00, ABU_RESP_OKAY);
        rchk(ABU_IDX_BP_ADDR_LO, 8'h00, ABU_RESP_OKAY);
        rchk(ABU_IDX_BP_STATUS_CTRL, 8'h00, ABU_RESP_OKAY);
        rchk(16'hFE13, 8'h00, ABU_RESP_SLVERR);
        wr(16'hFE13, 8'hFF, ABU_RESP_SLVERR);
        chk("break_vector", cpu_out.break_vector, ABU_VEC_USER);
        $display("t_reset done");
    endtask
    task automatic t_regs;
        wr(ABU_IDX_BP_ADDR_HI, 8'hA5, ABU_RESP_OKAY);
        wr(ABU_IDX_BP_ADDR_LO, 8'h5A, ABU_RESP_OKAY);
        rchk(ABU_IDX_BP_ADDR_HI, 8'hA5, ABU_RESP_OKAY);
        rchk(ABU_IDX_BP_ADDR_LO, 8'h5A, ABU_RESP_OKAY);
        wr(ABU_IDX_BP_STATUS_CTRL, 8'h80, ABU_RESP_OKAY);
        rchk(ABU_IDX_BP_STATUS_CTRL, 8'h80, ABU_RESP_OKAY);
        wr(ABU_IDX_BP_STATUS_CTRL, 8'h00, ABU_RESP_OKAY);
        $display("t_regs done");
    endtask
    task automatic t_match;
        wr(ABU_IDX_BP_ADDR_HI, 8'h12, ABU_RESP_OKAY);
        wr(ABU_IDX_BP_ADDR_LO, 8'h34, ABU_RESP_OKAY);
        wr(ABU_IDX_IRQ_MASK, 8'h02, ABU_RESP_OKAY);
        ctl.addr <= 16'h1234;
        ctl.addr_from_pc <= 1'b1;
        repeat (8) @(negedge clk);
        chk("break_req", cpu_out.break_req, 1'b0);
        @(posedge clk);
        ctl.addr_from_pc <= 1'b0;
        wr(ABU_IDX_BP_STATUS_CTRL, 8'h80, ABU_RESP_OKAY);
        repeat (8) @(negedge clk);
        chk("break_req", cpu_out.break_req, 1'b0);
        @(posedge clk);
        ctl.addr_from_pc <= 1'b1;
        take_break(ABU_VEC_USER, 1'b0);
        @(posedge clk);
        ctl.addr_from_pc <= 1'b0;
        @(negedge clk);
        chk("irq", irq, 1'b1);
        rchk(ABU_IDX_BP_STATUS_CTRL, 8'hC0, ABU_RESP_OKAY);
        wr(ABU_IDX_IRQ_STATUS, 8'h02, ABU_RESP_OKAY);
        @(negedge clk);
        chk("irq", irq, 1'b0);
        rchk(ABU_IDX_IRQ_STATUS, 8'h01, ABU_RESP_OKAY);
        end_break();
        wr(ABU_IDX_BP_STATUS_CTRL, 8'h80, ABU_RESP_OKAY);
        rchk(ABU_IDX_BP_STATUS_CTRL, 8'h80, ABU_RESP_OKAY);
        $display("t_match done");
    endtask
    task automatic t_soft;
        ctl.monitor_mode <= 1'b1;
        ctl.reset_pin_high_v <= 1'b1;
        ctl.wait_mode <= 1'b1;
        wr(ABU_IDX_BP_FLAG_CONTROL, 8'h00, ABU_RESP_OKAY);
        wr(ABU_IDX_BP_STATUS_CTRL, 8'h40, ABU_RESP_OKAY);
        take_break(ABU_VEC_MONITOR, 1'b1);
        chk("watchdog_disable", cpu_out.watchdog_disable, 1'b1);
        chk("periph_flag_clear_ok", cpu_out.periph_flag_clear_ok, 1'b0);
        wr(ABU_IDX_BP_FLAG_CONTROL, 8'h80, ABU_RESP_OKAY);
        @(negedge clk);
        chk("periph_flag_clear_ok", cpu_out.periph_flag_clear_ok, 1'b1);
        rchk(ABU_IDX_STOPWAIT_STATUS, 8'h02, ABU_RESP_OKAY);
        end_break();
        wr(ABU_IDX_BP_STATUS_CTRL, 8'h00, ABU_RESP_OKAY);
        wr(ABU_IDX_STOPWAIT_STATUS, 8'h02, ABU_RESP_OKAY);
        rchk(ABU_IDX_STOPWAIT_STATUS, 8'h00, ABU_RESP_OKAY);
        ctl <= '0;
        $display("t_soft done");
    endtask
    task automatic t_stop;
        wr(ABU_IDX_BP_STATUS_CTRL, 8'h80, ABU_RESP_OKAY);
        ctl.stop_mode <= 1'b1;
        ctl.addr <= 16'h1234;
        ctl.addr_from_pc <= 1'b1;
        repeat (8) @(negedge clk);
        chk("break_req", cpu_out.break_req, 1'b0);
        rchk(ABU_IDX_BP_ADDR_HI, 8'h12, ABU_RESP_OKAY);
        rchk(ABU_IDX_BP_STATUS_CTRL, 8'h80, ABU_RESP_OKAY);
        ctl.addr_from_pc <= 1'b0;
        wr(ABU_IDX_BP_STATUS_CTRL, 8'hC0, ABU_RESP_OKAY);
        take_break(ABU_VEC_USER, 1'b1);
        rchk(ABU_IDX_STOPWAIT_STATUS, 8'h02, ABU_RESP_OKAY);
        end_break();
        chk("sw_irq_count", sw_irq_count, 32'h0000_0003);
        $display("t_stop done");
    endtask
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_regs();
        t_match();
        t_soft();
        t_stop();
        finish_test();
    end
    // Whole run is well under two thousand cycles
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        finish_test();
    end
endmodule // abu_breakpoint_tb
`default_nettype wire
